/* shared/smi_router_pkg.sv */
// Purpose: Shared constants and types for the management-interrupt router.
// Assumes: 32-bit AHB-Lite register access, one register to an aligned word.
// Notes:   Register offsets are indexes; the byte address is four times the index.
package smi_router_pkg;

  // Register indexes; byte address is index times four.
  localparam logic [7:0] IDX_ENABLE_A   = 8'hB4;  // Source enables, first group.
  localparam logic [7:0] IDX_ENABLE_B   = 8'hB5;  // Source enables, second group.
  localparam logic [7:0] IDX_STATUS_A   = 8'hB6;  // Source status, first group.
  localparam logic [7:0] IDX_STATUS_B   = 8'hB7;  // Source status, second group.
  localparam logic [7:0] IDX_STANDBY    = 8'hB8;  // Reserved word, reads zero.
  localparam logic [7:0] IDX_KBD_OPTION = 8'hF0;  // Keyboard gate options.
  localparam logic [7:0] IDX_KBD_RSV_LO = 8'hF1;  // First reserved keyboard index.
  localparam logic [7:0] IDX_KBD_RSV_HI = 8'hFF;  // Last reserved keyboard index.

  // Address decode geometry.
  localparam int ADDR_INDEX_LSB = 2;   // Word alignment of every register.
  localparam int ADDR_INDEX_MSB = 9;   // Top bit of the eight-bit index.

  // Values after reset.
  localparam logic [7:0] RESET_ENABLE_A   = 8'h00;  // All first-group sources off.
  localparam logic [7:0] RESET_ENABLE_B   = 8'h00;  // All second-group sources off.
  localparam logic [7:0] RESET_STATUS     = 8'h00;  // No requests seen.
  localparam logic [7:0] RESET_KBD_OPTION = 8'h00;  // Active-low line, fast gate off.

  // Writable bits; all other bits are reserved.
  localparam logic [7:0] MASK_ENABLE_A   = 8'h9E;  // Bits 1,2,3,4,7.
  localparam logic [7:0] MASK_ENABLE_B   = 8'h57;  // Bits 0,1,2,4,6.
  localparam logic [7:0] MASK_KBD_OPTION = 8'h84;  // Bits 2 and 7.

  // First group bit positions.
  localparam int BIT_PARALLEL = 1;  // Parallel port request.
  localparam int BIT_SERIAL_B = 2;  // Second serial port request.
  localparam int BIT_SERIAL_A = 3;  // First serial port request.
  localparam int BIT_FLOPPY   = 4;  // Floppy controller request.
  localparam int BIT_WATCHDOG = 7;  // Watchdog request.

  // Second group bit positions.
  localparam int BIT_MOUSE      = 0;  // Mouse request.
  localparam int BIT_KEYBOARD   = 1;  // Keyboard request.
  localparam int BIT_INFRARED   = 2;  // Infrared receive transition.
  localparam int BIT_KBC_LINE   = 4;  // Keyboard controller port line one.
  localparam int BIT_SERIAL_IRQ = 6;  // Group request onto serial frame.

  // Keyboard option bit positions.
  localparam int BIT_FAST_GATE  = 2;  // Fast gate and reset port enable.
  localparam int BIT_LINE_POLAR = 7;  // Port line one polarity.

  // AHB-Lite encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;  // First beat of a transfer.
  localparam logic       HRESP_OKAY    = 1'h0;  // Only response this slave gives.
  localparam logic [31:0] READ_ZERO    = 32'h0000_0000;  // Unmapped read value.

  // Request lines from the peripheral units, all active high.
  typedef struct packed {
    logic parallel;  // Parallel port unit.
    logic serial_b;  // Second serial port.
    logic serial_a;  // First serial port.
    logic floppy;    // Floppy controller.
    logic watchdog;  // Watchdog timer.
    logic mouse;     // Auxiliary pointing device.
    logic keyboard;  // Keyboard.
  } irq_sources_t;

  localparam int SOURCE_COUNT = 7;  // Width of irq_sources_t.

  // Bus slave phase tracking.
  typedef enum logic [3:0] {
    PHASE_IDLE    = 4'h1,  // No data phase pending.
    PHASE_WRITE   = 4'h2,  // Write data phase, zero wait.
    PHASE_RD_WAIT = 4'h4,  // Read data being fetched, one wait.
    PHASE_RD_OUT  = 4'h8   // Read data on the bus.
  } bus_phase_t;

endpackage : smi_router_pkg

/* rtl/sync_bits.sv */
// Purpose: Two-flop synchroniser for a group of independent level signals.
// Assumes: Each bit changes slowly against the clock and is read as a level.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module sync_bits #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // One pair of flops per bit so each bit stands alone.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic stage_one;  // Metastable catch stage, read only by stage two.

      // Both stages clear to zero on reset.
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          stage_one   <= 1'b0;
          sync_out[g] <= 1'b0;
        end else begin
          stage_one   <= async_in[g];
          sync_out[g] <= stage_one;
        end
      end
    end
  endgenerate

endmodule : sync_bits

/* rtl/smi_event_router.sv */
// Purpose: Combine peripheral requests into one group management interrupt.
// Assumes: AHB-Lite single word transfers; peripheral lines are asynchronous.
// Notes:   Reads take one wait state; writes take none.
//
// Overview of operation
// (R1) Option bit 7 sets port line polarity.
// (R2) Option bit 2 enables fast gate port.
// (R3) Keyboard indexes F1 to FF read zero.
// (R4) First enable register gates first sources.
// (R5) Second enable gates mouse, keyboard, infrared, pin.
// (R6) Second enable bit 4 routes port line.
// (R7) Second enable bit 6 feeds serial stream.
// (R8) First status mirrors first group requests.
// (R9) First status ignores writes, follows sources.
// (R10) Mouse and keyboard status follow sources.
// (R11) Status bit 4 follows port line one.
// (R12) Infrared transition sets status bit 2.
// (R13) Reading second status clears infrared bit.
// (R14) Location select picks infrared receive pin.
// (R15) Group interrupt: status and enable, active low.
// (R16) Reserved bits read zero, ignore writes.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module smi_event_router (
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  // AHB-Lite slave.
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic      [31:0]                 hrdata,
  // Peripheral requests and pins.
  input  wire smi_router_pkg::irq_sources_t irq_sources,
  input  wire logic                        kbc_port_line_one,
  input  wire logic                        serial_b_receive_pin,
  input  wire logic                        alt_infrared_receive_pin,
  input  wire logic                        infrared_location_select,
  // Outputs.
  output logic                             group_mgmt_irq_n,
  output logic                             group_mgmt_irq_oe,
  output logic                             group_irq_serial_request,
  output logic                             kbc_port_line_one_out,
  output logic                             fast_gate_enable
);
  import smi_router_pkg::*;

  // Reset release chain; its output is the reset the design uses.
  logic       reset_stage;  // First release flop.
  logic       rst_n;        // Released reset.

  // Software-visible state.
  logic [7:0] smi_source_enable_a;    // First group enables.
  logic [7:0] smi_source_enable_b;    // Second group enables and routing.
  logic [7:0] smi_source_status_a;    // First group status mirror.
  logic [7:0] smi_source_status_b;    // Second group status.
  logic [7:0] keyboard_gate_options;  // Keyboard port options.

  // Synchronised inputs.
  irq_sources_t src_sync;      // Requests after two flops.
  logic         line_sync;     // Port line one after two flops.
  logic         rx_b_sync;     // Second serial receive after two flops.
  logic         rx_alt_sync;   // Alternate infrared receive after two flops.
  logic         loc_sync;      // Location select after two flops.

  // Infrared edge detection.
  logic         ir_rx;         // Selected receive level.
  logic         ir_prev;       // Previous selected level.
  logic         ir_primed;     // Previous level is valid.
  logic         ir_edge;       // Transition seen this cycle.

  // Bus slave state.
  bus_phase_t   phase;         // Current data phase kind.
  bus_phase_t   next_phase;    // Data phase kind after this edge.
  logic [7:0]   dp_index;      // Register index held for the data phase.
  logic         dp_mapped;     // Held address is inside the register window.
  logic         accept;        // Address phase taken at this edge.
  logic         read_clear;    // Read of second status is in its wait cycle now.
  logic         group_active;  // Any enabled status bit is set.

  // True when the address selects a given index and no higher bits are set.
  function automatic logic index_hit(input logic [7:0] index, input logic mapped,
                                     input logic [7:0] target);
    index_hit = mapped && (index == target);
  endfunction : index_hit

  // Release reset through two flops so every flop leaves reset together.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reset_stage <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      reset_stage <= 1'b1;
      rst_n       <= reset_stage;
    end
  end

  // Peripheral requests come from other clock regions, so they are synchronised.
  sync_bits #(
    .WIDTH    (SOURCE_COUNT + 4)
  ) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in ({irq_sources, kbc_port_line_one, serial_b_receive_pin,
                alt_infrared_receive_pin, infrared_location_select}),
    .sync_out ({src_sync, line_sync, rx_b_sync, rx_alt_sync, loc_sync})
  );

  // Pick the infrared receive source after the location mux.
  assign ir_rx = loc_sync ? rx_alt_sync : rx_b_sync;  // R14

  // Edges count only once a previous level has been captured; a line that idles high
  // still shows one transition after reset, as the synchroniser output starts at zero.
  assign ir_edge = ir_primed && (ir_rx != ir_prev);  // R12

  // Remember the previous receive level.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ir_prev   <= 1'b0;
      ir_primed <= 1'b0;
    end else begin
      ir_prev   <= ir_rx;
      ir_primed <= 1'b1;
    end
  end

  // An address phase is taken when selected, active and the bus is ready.
  assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);

  // The read that clears the infrared bit is the one that loads the data.
  assign read_clear = (phase == PHASE_RD_WAIT) && index_hit(dp_index, dp_mapped, IDX_STATUS_B);

  // Only the fetch cycle of a read holds the bus.
  assign hreadyout = (phase != PHASE_RD_WAIT);
  assign hresp     = HRESP_OKAY;

  // Choose the next data phase.
  always_comb begin
    next_phase = phase;
    case (phase)
      PHASE_RD_WAIT: begin
        // The fetch always completes in one cycle.
        next_phase = PHASE_RD_OUT;
      end
      PHASE_IDLE, PHASE_WRITE, PHASE_RD_OUT: begin
        // Bus is ready here, so a new address phase may start.
        if (accept) begin
          next_phase = hwrite ? PHASE_WRITE : PHASE_RD_WAIT;
        end else begin
          next_phase = PHASE_IDLE;
        end
      end
      default: begin
        // Recover from an illegal code.
        next_phase = PHASE_IDLE;
      end
    endcase
  end

  // Data phase tracking.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PHASE_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // Hold the address for the data phase; any high address bit means unmapped.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dp_index  <= 8'h00;
      dp_mapped <= 1'b0;
    end else if (accept && hreadyout) begin
      dp_index  <= haddr[ADDR_INDEX_MSB:ADDR_INDEX_LSB];
      dp_mapped <= (haddr[31:ADDR_INDEX_MSB+1] == '0) && (haddr[ADDR_INDEX_LSB-1:0] == '0);
    end
  end

  // First enable register: only documented bits take writes.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      smi_source_enable_a <= RESET_ENABLE_A;
    end else if (phase == PHASE_WRITE && index_hit(dp_index, dp_mapped, IDX_ENABLE_A)) begin
      smi_source_enable_a <= hwdata[7:0] & MASK_ENABLE_A;  // R4 R16
    end
  end

  // Second enable register: source gates plus routing controls.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      smi_source_enable_b <= RESET_ENABLE_B;
    end else if (phase == PHASE_WRITE && index_hit(dp_index, dp_mapped, IDX_ENABLE_B)) begin
      smi_source_enable_b <= hwdata[7:0] & MASK_ENABLE_B;  // R5 R6 R7 R16
    end
  end

  // Keyboard option register: polarity and fast gate enable.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      keyboard_gate_options <= RESET_KBD_OPTION;
    end else if (phase == PHASE_WRITE && index_hit(dp_index, dp_mapped, IDX_KBD_OPTION)) begin
      keyboard_gate_options <= hwdata[7:0] & MASK_KBD_OPTION;  // R16
    end
  end

  // First status mirrors its sources; host writes have no path into it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      smi_source_status_a <= RESET_STATUS;
    end else begin
      smi_source_status_a               <= RESET_STATUS;  // R16
      smi_source_status_a[BIT_PARALLEL] <= src_sync.parallel;  // R8 R9
      smi_source_status_a[BIT_SERIAL_B] <= src_sync.serial_b;  // R8 R9
      smi_source_status_a[BIT_SERIAL_A] <= src_sync.serial_a;  // R8 R9
      smi_source_status_a[BIT_FLOPPY]   <= src_sync.floppy;  // R8 R9
      smi_source_status_a[BIT_WATCHDOG] <= src_sync.watchdog;  // R8 R9
    end
  end

  // Second status: level bits follow sources, the infrared bit is sticky.
  // A transition in the same cycle as the clearing read wins, so no edge is lost.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      smi_source_status_b <= RESET_STATUS;
    end else begin
      smi_source_status_b               <= RESET_STATUS;  // R16
      smi_source_status_b[BIT_MOUSE]    <= src_sync.mouse;  // R10
      smi_source_status_b[BIT_KEYBOARD] <= src_sync.keyboard;  // R10
      smi_source_status_b[BIT_KBC_LINE] <= line_sync;  // R11
      if (ir_edge) begin
        smi_source_status_b[BIT_INFRARED] <= 1'b1;  // R12
      end else if (read_clear) begin
        smi_source_status_b[BIT_INFRARED] <= 1'b0;  // R13
      end else begin
        smi_source_status_b[BIT_INFRARED] <= smi_source_status_b[BIT_INFRARED];
      end
    end
  end

  // Read data is loaded in the wait cycle so it comes from a flop.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= READ_ZERO;
    end else if (phase == PHASE_RD_WAIT) begin
      hrdata <= READ_ZERO;
      if (index_hit(dp_index, dp_mapped, IDX_ENABLE_A)) begin
        hrdata[7:0] <= smi_source_enable_a;
      end else if (index_hit(dp_index, dp_mapped, IDX_ENABLE_B)) begin
        hrdata[7:0] <= smi_source_enable_b;
      end else if (index_hit(dp_index, dp_mapped, IDX_STATUS_A)) begin
        hrdata[7:0] <= smi_source_status_a;
      end else if (index_hit(dp_index, dp_mapped, IDX_STATUS_B)) begin
        hrdata[7:0] <= smi_source_status_b;
      end else if (index_hit(dp_index, dp_mapped, IDX_KBD_OPTION)) begin
        hrdata[7:0] <= keyboard_gate_options;
      end else begin
        // Reserved keyboard indexes, the standby word and unmapped space read zero.
        hrdata <= READ_ZERO;  // R3
      end
    end
  end

  // Any status bit paired with its enable raises the group request.
  assign group_active = |(smi_source_status_a & smi_source_enable_a)  // R4 R15
                      | |(smi_source_status_b & smi_source_enable_b);  // R5 R6 R15

  // Group outputs are registered so the pin never glitches.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      group_mgmt_irq_n         <= 1'b1;
      group_mgmt_irq_oe        <= 1'b0;
      group_irq_serial_request <= 1'b0;
    end else begin
      group_mgmt_irq_n         <= ~group_active;  // R15
      // The pin is driven only while some source is routed onto the group.
      group_mgmt_irq_oe        <= |smi_source_enable_a | |smi_source_enable_b[BIT_KBC_LINE:0];  // R5
      group_irq_serial_request <= group_active & smi_source_enable_b[BIT_SERIAL_IRQ];  // R7
    end
  end

  // Keyboard port outputs: polarity applied to the line, fast gate from its bit.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      kbc_port_line_one_out <= 1'b1;
      fast_gate_enable      <= 1'b0;
    end else begin
      // Cleared bit means the line idles high and asserts low.
      kbc_port_line_one_out <= keyboard_gate_options[BIT_LINE_POLAR] ? line_sync : ~line_sync;  // R1
      fast_gate_enable      <= keyboard_gate_options[BIT_FAST_GATE];  // R2
    end
  end

endmodule : smi_event_router

/* dv/smi_event_router_checker.sv */
// Purpose: Port-level assertions for the management-interrupt router.
// Assumes: Settings are shadowed here from the AHB-Lite writes seen at the ports.
// Notes:   Level checks wait for quiet inputs, since inputs pass synchronisers.
`timescale 1ns/1ps
module smi_event_router_checker (
  input wire logic                         clock,
  input wire logic                         reset_n,
  input wire logic                         hsel,
  input wire logic [31:0]                  haddr,
  input wire logic [1:0]                   htrans,
  input wire logic                         hwrite,
  input wire logic [31:0]                  hwdata,
  input wire logic                         hready,
  input wire logic                         hreadyout,
  input wire logic [31:0]                  hrdata,
  input wire smi_router_pkg::irq_sources_t irq_sources,
  input wire logic                         kbc_port_line_one,
  input wire logic                         group_mgmt_irq_n,
  input wire logic                         group_mgmt_irq_oe,
  input wire logic                         group_irq_serial_request,
  input wire logic                         kbc_port_line_one_out,
  input wire logic                         fast_gate_enable
);
  import smi_router_pkg::*;
  logic        ap_wr, ap_rd;          // A data phase is pending.
  logic [7:0]  ap_idx;                // Index taken in the address phase.
  logic [7:0]  en_a, en_b, opt;       // Shadows of the writable registers.
  logic [3:0]  age;                   // Quiet cycles counted before this edge.
  logic [24:0] prev;                  // Causes seen one cycle ago.
  wire logic [24:0] cur  = {irq_sources, kbc_port_line_one, en_a, en_b, opt[BIT_LINE_POLAR]};
  wire logic        take = hsel && hready && htrans == HTRANS_NONSEQ && haddr[31:10] == 22'h0
                           && haddr[1:0] == 2'h0;
  wire logic [7:0]  sa   = {irq_sources.watchdog, 2'b0, irq_sources.floppy, irq_sources.serial_a,
                            irq_sources.serial_b, irq_sources.parallel, 1'b0};
  wire logic [7:0]  sb   = {3'b0, kbc_port_line_one, 2'b0, irq_sources.keyboard, irq_sources.mouse};
  wire logic        act  = |(sa & en_a) || |(sb & en_b);
  wire logic [3:0]  quiet = (cur != prev) ? 4'h0 : age;  // Zero when a cause just changed.

  // Track bus phases and mirror writes; hready low holds a read in its wait.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ap_wr  <= 1'b0;
      ap_rd  <= 1'b0;
      ap_idx <= 8'h00;
      en_a   <= 8'h00;
      en_b   <= 8'h00;
      opt    <= 8'h00;
    end else if (hready) begin
      ap_wr  <= take && hwrite;
      ap_rd  <= take && !hwrite;
      ap_idx <= haddr[9:2];
      if (ap_wr && ap_idx == IDX_ENABLE_A) en_a <= hwdata[7:0] & MASK_ENABLE_A;
      if (ap_wr && ap_idx == IDX_ENABLE_B) en_b <= hwdata[7:0] & MASK_ENABLE_B;
      if (ap_wr && ap_idx == IDX_KBD_OPTION) opt <= hwdata[7:0] & MASK_KBD_OPTION;
    end
  end

  // Count quiet cycles, saturating, so level checks skip synchroniser latency.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prev  <= 25'h0;
      age   <= 4'h0;
    end else begin
      prev  <= cur;
      age   <= (quiet == 4'hF) ? 4'hF : quiet + 4'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_line_polarity;
    quiet >= 4'h6 |-> kbc_port_line_one_out == (opt[BIT_LINE_POLAR] ? kbc_port_line_one : !kbc_port_line_one);
  endproperty
  a_line_polarity: assert property (p_line_polarity) else $error("port line polarity wrong");
  property p_fast_gate;
    $changed(opt[BIT_FAST_GATE]) |-> ##[0:2] fast_gate_enable == opt[BIT_FAST_GATE];
  endproperty
  a_fast_gate: assert property (p_fast_gate) else $error("fast gate enable wrong");
  property p_reserved_read;
    ap_rd && hreadyout && ap_idx >= IDX_KBD_RSV_LO |-> hrdata == READ_ZERO;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved index not zero");
  property p_group_irq;
    quiet >= 4'h6 && !en_b[BIT_INFRARED] |-> group_mgmt_irq_n == !act;
  endproperty
  a_group_irq: assert property (p_group_irq) else $error("group interrupt level wrong");
  property p_serial;
    quiet >= 4'h6 && !en_b[BIT_INFRARED] |-> group_irq_serial_request == (en_b[BIT_SERIAL_IRQ] && act);
  endproperty
  a_serial: assert property (p_serial) else $error("serial request wrong");
  property p_oe;
    quiet >= 4'h3 |-> group_mgmt_irq_oe == (|en_a || |(en_b & 8'h17));
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_status_read;
    ap_rd && hreadyout && ap_idx == IDX_STATUS_A && quiet >= 4'h8 |-> hrdata[7:0] == sa;
  endproperty
  a_status_read: assert property (p_status_read) else $error("first status wrong");
  property p_upper_zero;
    hrdata[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_read_wait;
    take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
endmodule : smi_event_router_checker

/* dv/tb_top.sv */
// Purpose: Self-checking bench for the management-interrupt router.
// Assumes: One AHB-Lite master here; hready is the slave's hreadyout.
// Notes:   Expected read data is queued by the driver and checked by a monitor.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t got %h expected %h", $time, g, e); end end
module tb_top;
  import smi_router_pkg::*;
  logic          clock = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0]   haddr = 32'h0, hwdata = 32'h0, hrdata, exp_v;
  logic [1:0]    htrans = 2'h0;
  logic [2:0]    hsize = 3'h2;
  logic          hreadyout, hresp, rd_phase = 1'b0;
  irq_sources_t  irq_sources = '0, s;
  logic          kbc_port_line_one = 1'b0, serial_b_receive_pin = 1'b0, act;
  logic          alt_infrared_receive_pin = 1'b0, infrared_location_select = 1'b0;
  logic          group_mgmt_irq_n, group_mgmt_irq_oe, group_irq_serial_request;
  logic          kbc_port_line_one_out, fast_gate_enable, l;
  logic [7:0]    d, ea, eb, sbv;
  logic [31:0]   exp_q[$];        // Expected read data, oldest first.
  int            n_errors = 0, check_count = 0, seed = 38517;
  wire logic     hready = hreadyout;

  smi_event_router dut (.clock, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .irq_sources, .kbc_port_line_one, .serial_b_receive_pin,
    .alt_infrared_receive_pin, .infrared_location_select, .group_mgmt_irq_n, .group_mgmt_irq_oe,
    .group_irq_serial_request, .kbc_port_line_one_out, .fast_gate_enable);

  // Free-running bus clock.
  initial begin
    forever #2 clock = ~clock;
  end

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // Wait for hready high at a rising edge; a hang counts as a mismatch.
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_errors++;
        tally_and_finish();
      end
      @(posedge clock);
    end
  endtask : wait_rdy

  // One single word transfer; the address phase holds until hready is seen.
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] v);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, v};
    rd_phase <= !w;
    wait_rdy();
    rd_phase <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    xfer(1'b1, idx, v);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    xfer(1'b0, idx, 8'h00);
  endtask : rd

  function automatic logic [7:0] sa_of(input irq_sources_t x);
    return {x.watchdog, 2'b0, x.floppy, x.serial_a, x.serial_b, x.parallel, 1'b0};
  endfunction : sa_of

  // Compare each read result with the oldest noted expectation.
  always @(posedge clock) begin
    if (rd_phase && hreadyout) begin
      exp_v = exp_q.pop_front();
      `CHK(hrdata, exp_v)
    end
  end

  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(IDX_ENABLE_A, 8'h00);
    rd(IDX_ENABLE_B, 8'h00);
    rd(IDX_STATUS_A, 8'h00);
    rd(IDX_STATUS_B, 8'h00);
    rd(IDX_KBD_OPTION, 8'h00);
    for (int i = 'hF1; i <= 'hFF; i++) begin
      wr(8'(i), 8'hFF);
      rd(8'(i), 8'h00);
    end
    wr(IDX_STANDBY, 8'hFF);
    rd(IDX_STANDBY, 8'h00);
    $display("test reset_and_reserved done");
    repeat (4) begin
      d = 8'($random(seed));
      wr(IDX_ENABLE_A, d);
      rd(IDX_ENABLE_A, d & 8'h9E);
      wr(IDX_ENABLE_B, ~d);
      rd(IDX_ENABLE_B, ~d & 8'h57);
    end
    $display("test enable_access done");
    for (int k = 0; k < 2; k++) begin
      d = k ? 8'hFF : 8'h7B;
      wr(IDX_KBD_OPTION, d);
      rd(IDX_KBD_OPTION, d & 8'h84);
      for (int m = 0; m < 2; m++) begin
        kbc_port_line_one <= m[0];
        repeat (8) @(posedge clock);
        `CHK(kbc_port_line_one_out, d[7] ? m[0] : !m[0])
        `CHK(fast_gate_enable, d[2])
      end
    end
    $display("test keyboard_options done");
    // Random sources and enables; the infrared enable stays off here.
    repeat (12) begin
      s = irq_sources_t'(7'($random(seed)));
      l = 1'($random(seed));
      ea = 8'($random(seed));
      eb = 8'($random(seed)) & 8'hFB;
      wr(IDX_ENABLE_A, ea);
      wr(IDX_ENABLE_B, eb);
      irq_sources <= s;
      kbc_port_line_one <= l;
      repeat (8) @(posedge clock);
      rd(IDX_STATUS_A, sa_of(s));
      wr(IDX_STATUS_A, 8'hFF);
      rd(IDX_STATUS_A, sa_of(s));
      sbv = {3'b0, l, 2'b0, s.keyboard, s.mouse};
      rd(IDX_STATUS_B, sbv);
      act = |(sa_of(s) & ea) || |(sbv & eb & 8'h13);
      `CHK(group_mgmt_irq_n, !act)
      `CHK(group_irq_serial_request, act && eb[6])
      `CHK(group_mgmt_irq_oe, |(ea & 8'h9E) || |(eb & 8'h17))
    end
    $display("test source_routing done");
    irq_sources <= '0;
    kbc_port_line_one <= 1'b0;
    wr(IDX_ENABLE_B, 8'h04);
    serial_b_receive_pin <= 1'b1;
    repeat (8) @(posedge clock);
    `CHK(group_mgmt_irq_n, 1'b0)
    rd(IDX_STATUS_B, 8'h04);
    rd(IDX_STATUS_B, 8'h00);
    repeat (8) @(posedge clock);
    `CHK(group_mgmt_irq_n, 1'b1)
    alt_infrared_receive_pin <= 1'b1;
    repeat (8) @(posedge clock);
    infrared_location_select <= 1'b1;
    repeat (8) @(posedge clock);
    serial_b_receive_pin <= 1'b0;
    repeat (8) @(posedge clock);
    rd(IDX_STATUS_B, 8'h00);
    alt_infrared_receive_pin <= 1'b0;
    repeat (8) @(posedge clock);
    rd(IDX_STATUS_B, 8'h04);
    $display("test infrared_edges done");
    tally_and_finish();
  end
endmodule : tb_top

bind smi_event_router smi_event_router_checker u_chk (.clock, .reset_n, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hrdata, .irq_sources, .kbc_port_line_one, .group_mgmt_irq_n,
  .group_mgmt_irq_oe, .group_irq_serial_request, .kbc_port_line_one_out, .fast_gate_enable);
